// ### common/acreg_defs.vh
// acreg_defs.vh: register map, field positions, reset values and timing for the codec control bank
// assumes: included by the control bank and its soft-step helper
`ifndef ACREG_DEFS_VH
`define ACREG_DEFS_VH

// register word addresses carried in the serial command
`define ACREG_ADDR_W 6
`define ACREG_PATH_CFG_ADDR 6'h00
`define ACREG_GAIN_CFG_ADDR 6'h01

// audio_path_config field positions
`define ACREG_CORNER_HI 15
`define ACREG_CORNER_LO 14
`define ACREG_LSRC_HI 13
`define ACREG_LSRC_LO 12
`define ACREG_RSRC_HI 11
`define ACREG_RSRC_LO 10
`define ACREG_MIC_PREAMP_GAIN_SEL_HI 9
`define ACREG_MIC_PREAMP_GAIN_SEL_LO 8
`define ACREG_MCLK_HI 7
`define ACREG_MCLK_LO 6
`define ACREG_RATE_HI 5
`define ACREG_RATE_LO 2
`define ACREG_FMT_HI 1
`define ACREG_FMT_LO 0

// record_gain_config field positions
`define ACREG_LMUTE_BIT 15
`define ACREG_LGAIN_HI 14
`define ACREG_LGAIN_LO 8
`define ACREG_RMUTE_BIT 7
`define ACREG_RGAIN_HI 6
`define ACREG_RGAIN_LO 0

// reset values, gain floor and highest legal rate code
`define ACREG_PATH_CFG_RST 16'hc003
`define ACREG_GAIN_CFG_RST 16'hd7d7
`define ACREG_GAIN_MIN 7'h07
`define ACREG_GAIN_MAX_RATE 4'h8

// soft-step period: 20 us per half-dB step at 4 ns clock
`define ACREG_STEP_US 20
`define ACREG_CLK_NS 4
`define ACREG_STEP_CYCLES ((`ACREG_STEP_US * 1000) / `ACREG_CLK_NS)

`endif

// ### verilog/acreg_soft_step.v
// acreg_soft_step.v: one record channel's gain soft-stepper and hard-mute control
// assumes: step_tick_i is a one-cycle pulse from the same clock domain
`timescale 1ns/100ps
`default_nettype none
`include "acreg_defs.vh"

module acreg_soft_step (
    input wire core_clk_i,
    input wire reset_i,
    input wire step_tick_i,
    input wire mute_req_i,
    input wire [6:0] target_gain_i,
    output reg [6:0] applied_gain_o,
    output reg hard_mute_o
);
    wire mute_wanted;
    wire [6:0] goal;

    // a code under the floor behaves as a mute request; the stored code is untouched
    assign mute_wanted = mute_req_i | (target_gain_i < `ACREG_GAIN_MIN);
    assign goal = mute_wanted ? `ACREG_GAIN_MIN : target_gain_i;

    // one half-dB step per tick; mute closes only once the floor is reached, and
    // opens before stepping up, so no pop on either edge
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            applied_gain_o <= 7'h07;
            hard_mute_o <= 1'b1;
        end else if (step_tick_i) begin
            if (mute_wanted && applied_gain_o == `ACREG_GAIN_MIN) begin
                hard_mute_o <= 1'b1;
            end else if (!mute_wanted && hard_mute_o) begin
                hard_mute_o <= 1'b0;
            end else if (applied_gain_o < goal) begin
                applied_gain_o <= applied_gain_o + 7'h01;
            end else if (applied_gain_o > goal) begin
                applied_gain_o <= applied_gain_o - 7'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ### verilog/acreg_control_bank.v
// acreg_control_bank.v: audio codec control registers written over the serial control port
// assumes: serial clock, select and data come from the host pins, asynchronous to core_clk_i;
// command word is 16 bits (r/w, 6-bit address, 9 spare) followed by a 16-bit data word, msb first
// limitation: each ser_clk phase must last three core cycles or the synchronisers miss edges
// a frame cut short by select leaves every register as it was
//
// How it works
// - corner code picks dc-block filter response
// - left source code routes left converter input
// - right source code routes right converter input
// - mic gain codes give 0, 6, 12 dB
// - master clock ratio 256, 384, 512 Fs
// - four-bit rate code sets sample rate
// - format code selects justification and width
// - gain word holds mutes and seven-bit gains
// - gain spans -40 to +20 dB
// - hard mute ties input to common mode
// - gain codes 7f, 57, 07; below mutes
// - mute soft-steps down, keeps stored gain
`timescale 1ns/100ps
`default_nettype none
`include "acreg_defs.vh"

module acreg_control_bank #(
    parameter STEP_CYCLES = `ACREG_STEP_CYCLES
) (
    input wire core_clk_i,
    input wire reset_i,
    input wire ser_clk_i,
    input wire ser_sel_n_i,
    input wire ser_din_i,
    output reg ser_dout_o,
    output reg ser_dout_oe_n_o,
    output reg [1:0] dc_block_corner_sel_o,
    output reg filter_bypass_o,
    output reg [1:0] left_record_source_sel_o,
    output reg [1:0] right_record_source_sel_o,
    output reg [2:0] mic_preamp_gain_db_o,
    output reg [9:0] mclk_ratio_o,
    output reg [3:0] sample_rate_code_o,
    output reg rate_code_invalid_o,
    output reg [1:0] audio_word_format_sel_o,
    output reg [6:0] left_applied_gain_o,
    output reg [6:0] right_applied_gain_o,
    output reg left_common_mode_tie_o,
    output reg right_common_mode_tie_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CMD = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_DONE = 2'd3;

    // preamp gain codes: 12 dB cannot be held as a three-bit dB count, so it is sent as 4
    localparam [2:0] MIC_GAIN_0DB = 3'd0;
    localparam [2:0] MIC_GAIN_6DB = 3'd6;
    localparam [2:0] MIC_GAIN_12DB = 3'd4;

    // master clock ratios as plain multiples of the sample rate
    localparam [9:0] RATIO_256 = 10'd256;
    localparam [9:0] RATIO_384 = 10'd384;
    localparam [9:0] RATIO_512 = 10'd512;

    // two-stage synchronisers plus a clock history stage; stage one is never read by logic
    reg [2:0] sclk_sync_reg;
    reg [1:0] sel_sync_reg;
    reg [1:0] din_sync_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [4:0] bit_cnt_reg;
    reg [15:0] shift_reg;
    reg [15:0] cmd_reg;
    reg [15:0] rd_shift_reg;
    reg [15:0] path_cfg_reg;
    reg [15:0] gain_cfg_reg;
    reg [31:0] tick_cnt_reg;
    reg step_tick_reg;
    wire sclk_rise;
    wire sclk_fall;
    wire sel_active;
    wire [6:0] left_gain;
    wire [6:0] right_gain;
    wire left_mute;
    wire right_mute;
    wire [15:0] word_in;
    wire word_end;
    wire [1:0] corner_code;
    wire [3:0] rate_code;

    // returns the selected register word
    function [15:0] read_mux;
        input [5:0] addr;
        input [15:0] path_word;
        input [15:0] gain_word;
        begin
            case (addr)
                `ACREG_PATH_CFG_ADDR: read_mux = path_word;
                `ACREG_GAIN_CFG_ADDR: read_mux = gain_word;
                default: read_mux = 16'h0000;
            endcase
        end
    endfunction

    // preamp gain code to its output code
    function [2:0] mic_gain_decode;
        input [1:0] code;
        begin
            case (code)
                2'b10: mic_gain_decode = MIC_GAIN_6DB;
                2'b11: mic_gain_decode = MIC_GAIN_12DB;
                default: mic_gain_decode = MIC_GAIN_0DB;
            endcase
        end
    endfunction

    // master clock ratio code to its multiple; code 11 repeats the default
    function [9:0] ratio_decode;
        input [1:0] code;
        begin
            case (code)
                2'b01: ratio_decode = RATIO_384;
                2'b10: ratio_decode = RATIO_512;
                default: ratio_decode = RATIO_256;
            endcase
        end
    endfunction

    // link clock: two sync stages plus one history stage for edge detection;
    // resets to the idle low level so no false edge follows reset
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            sclk_sync_reg <= 3'b000;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk_i};
        end
    end

    // select: resets to the deselected level so no frame starts out of reset
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            sel_sync_reg <= 2'b11;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], ser_sel_n_i};
        end
    end

    // data: same two stages as the clock so a bit and its edge stay aligned
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            din_sync_reg <= 2'b00;
        end else begin
            din_sync_reg <= {din_sync_reg[0], ser_din_i};
        end
    end

    // edge detection uses stage two and a third history stage, never stage one
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign sel_active = ~sel_sync_reg[1];

    // the word as it stands once the current bit is in; a word ends on its sixteenth rising edge
    assign word_in = {shift_reg[14:0], din_sync_reg[1]};
    assign word_end = sclk_rise && bit_cnt_reg == 5'd15;

    // frame sequencing: command word then data word; select going high aborts
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (sel_active) state_next = ST_CMD;
            ST_CMD: if (!sel_active) state_next = ST_IDLE;
                else if (word_end) state_next = ST_DATA;
            ST_DATA: if (!sel_active) state_next = ST_IDLE;
                else if (word_end) state_next = ST_DONE;
            ST_DONE: if (!sel_active) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // serial shifter and register writes; the host drives the writes, gain changes are stepped below
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 5'd0;
            shift_reg <= 16'h0000;
            cmd_reg <= 16'h0000;
            rd_shift_reg <= 16'h0000;
            path_cfg_reg <= `ACREG_PATH_CFG_RST;
            gain_cfg_reg <= `ACREG_GAIN_CFG_RST;
            ser_dout_o <= 1'b0;
            ser_dout_oe_n_o <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE || !sel_active) begin
                bit_cnt_reg <= 5'd0;
                ser_dout_oe_n_o <= 1'b1;
            end else if (sclk_rise && state_reg != ST_DONE) begin
                shift_reg <= word_in;
                bit_cnt_reg <= (bit_cnt_reg == 5'd15) ? 5'd0 : bit_cnt_reg + 5'd1;
                if (bit_cnt_reg == 5'd15 && state_reg == ST_CMD) begin
                    cmd_reg <= word_in;
                    rd_shift_reg <= read_mux(shift_reg[13:8], path_cfg_reg, gain_cfg_reg);
                end
                if (bit_cnt_reg == 5'd15 && state_reg == ST_DATA && !cmd_reg[15]) begin
                    case (cmd_reg[14:9])
                        `ACREG_PATH_CFG_ADDR: path_cfg_reg <= word_in;
                        `ACREG_GAIN_CFG_ADDR: gain_cfg_reg <= word_in;
                        default: ;
                    endcase
                end
            end else if (sclk_fall && state_reg == ST_DATA && cmd_reg[15]) begin
                // read data leaves msb first on falling edges while the host samples on rising
                ser_dout_o <= rd_shift_reg[15];
                rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
                ser_dout_oe_n_o <= 1'b0;
            end
        end
    end

    // free-running step timer; every channel steps on the same tick
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            tick_cnt_reg <= 32'd0;
            step_tick_reg <= 1'b0;
        end else if (tick_cnt_reg == STEP_CYCLES - 1) begin
            tick_cnt_reg <= 32'd0;
            step_tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'd1;
            step_tick_reg <= 1'b0;
        end
    end

    // field extraction from the gain word
    assign left_mute = gain_cfg_reg[`ACREG_LMUTE_BIT];
    assign left_gain = gain_cfg_reg[`ACREG_LGAIN_HI:`ACREG_LGAIN_LO];
    assign right_mute = gain_cfg_reg[`ACREG_RMUTE_BIT];
    assign right_gain = gain_cfg_reg[`ACREG_RGAIN_HI:`ACREG_RGAIN_LO];

    // path fields read by more than one output
    assign corner_code = path_cfg_reg[`ACREG_CORNER_HI:`ACREG_CORNER_LO];
    assign rate_code = path_cfg_reg[`ACREG_RATE_HI:`ACREG_RATE_LO];

    wire [6:0] left_step_gain;
    wire [6:0] right_step_gain;
    wire left_step_mute;
    wire right_step_mute;

    acreg_soft_step u_left_step (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .step_tick_i(step_tick_reg),
        .mute_req_i(left_mute),
        .target_gain_i(left_gain),
        .applied_gain_o(left_step_gain),
        .hard_mute_o(left_step_mute)
    );

    acreg_soft_step u_right_step (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .step_tick_i(step_tick_reg),
        .mute_req_i(right_mute),
        .target_gain_i(right_gain),
        .applied_gain_o(right_step_gain),
        .hard_mute_o(right_step_mute)
    );

    // path field outputs, all registered so the analog side sees clean levels
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            dc_block_corner_sel_o <= 2'b11;
            filter_bypass_o <= 1'b0;
            left_record_source_sel_o <= 2'b00;
            right_record_source_sel_o <= 2'b00;
            mic_preamp_gain_db_o <= MIC_GAIN_0DB;
            mclk_ratio_o <= RATIO_256;
            sample_rate_code_o <= 4'h0;
            rate_code_invalid_o <= 1'b0;
            audio_word_format_sel_o <= 2'b11;
        end else begin
            dc_block_corner_sel_o <= corner_code;
            filter_bypass_o <= corner_code == 2'b00;
            left_record_source_sel_o <= path_cfg_reg[`ACREG_LSRC_HI:`ACREG_LSRC_LO];
            right_record_source_sel_o <= path_cfg_reg[`ACREG_RSRC_HI:`ACREG_RSRC_LO];
            mic_preamp_gain_db_o <= mic_gain_decode(path_cfg_reg[`ACREG_MIC_PREAMP_GAIN_SEL_HI:`ACREG_MIC_PREAMP_GAIN_SEL_LO]);
            mclk_ratio_o <= ratio_decode(path_cfg_reg[`ACREG_MCLK_HI:`ACREG_MCLK_LO]);
            sample_rate_code_o <= rate_code;
            // flag only; the host must not write these codes, and the code still passes through
            rate_code_invalid_o <= rate_code > `ACREG_GAIN_MAX_RATE;
            audio_word_format_sel_o <= path_cfg_reg[`ACREG_FMT_HI:`ACREG_FMT_LO];
        end
    end

    // stepped gains and mute ties; one more register stage after the steppers
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            left_applied_gain_o <= 7'h07;
            right_applied_gain_o <= 7'h07;
            left_common_mode_tie_o <= 1'b1;
            right_common_mode_tie_o <= 1'b1;
        end else begin
            left_applied_gain_o <= left_step_gain;
            right_applied_gain_o <= right_step_gain;
            left_common_mode_tie_o <= left_step_mute;
            right_common_mode_tie_o <= right_step_mute;
        end
    end
endmodule

`default_nettype wire

// ### sim/acreg_host_model.sv
// acreg_host_model.sv: behavioural host that writes and reads the codec bank over its serial port
// assumes: the bench calls xfer; the link clock idles low and runs only inside frames
`timescale 1ns/100ps
`default_nettype none
module acreg_host_model (
    output logic ser_clk_o,
    output logic ser_sel_n_o,
    output logic ser_din_o,
    input wire logic ser_dout_i
);
    // idle: select high, clock still
    initial begin
        ser_clk_o = 1'b0;
        ser_sel_n_o = 1'b1;
        ser_din_o = 1'b1;
    end
    // one frame msb first; nbits under 32 lifts select early, an abort
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        ser_sel_n_o = 1'b0;
        #32;
        for (int i = 31; i >= 32 - nbits; i--) begin
            ser_din_o = word[i];
            #32 ser_clk_o = 1'b1;
            if (i < 16) rd = {rd[14:0], ser_dout_i};
            #32 ser_clk_o = 1'b0;
        end
        #32 ser_sel_n_o = 1'b1;
        ser_din_o = ~ser_din_o; // released line must not show a stale bit
        #40;
    endtask
endmodule
`default_nettype wire

// ### sim/acreg_control_bank_assertions.sv
// acreg_control_bank_assertions.sv: port-level checks of the codec control bank
// assumes: bound onto acreg_control_bank, one clock domain, reset synchronous high
`timescale 1ns/100ps
`default_nettype none
module acreg_control_bank_assertions #(
    parameter int STEP_CYCLES = 4
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ser_sel_n_i,
    input wire logic ser_dout_oe_n_o,
    input wire logic [1:0] dc_block_corner_sel_o,
    input wire logic filter_bypass_o,
    input wire logic [2:0] mic_preamp_gain_db_o,
    input wire logic [9:0] mclk_ratio_o,
    input wire logic [3:0] sample_rate_code_o,
    input wire logic rate_code_invalid_o,
    input wire logic [1:0] audio_word_format_sel_o,
    input wire logic [6:0] left_applied_gain_o,
    input wire logic [6:0] right_applied_gain_o,
    input wire logic left_common_mode_tie_o,
    input wire logic right_common_mode_tie_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic [7:0] quiet_cnt;
    // cycles since the left gain last moved; saturates so long idle spans stay legal
    always_ff @(posedge core_clk_i) begin
        if (reset_i || $changed(left_applied_gain_o)) begin
            quiet_cnt <= 8'h00;
        end else if (quiet_cnt != 8'hff) begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end
    a_bypass_decode: assert property (filter_bypass_o == (dc_block_corner_sel_o == 2'b00))
        else $error("bypass flag disagrees with corner code");
    a_mic_gain_code: assert property (mic_preamp_gain_db_o inside {3'd0, 3'd6, 3'd4})
        else $error("mic gain code out of set");
    a_ratio_values: assert property (mclk_ratio_o inside {10'd256, 10'd384, 10'd512})
        else $error("clock ratio out of set");
    a_rate_flag: assert property (rate_code_invalid_o == (sample_rate_code_o > 4'h8))
        else $error("rate invalid flag wrong");
    a_gain_floor: assert property (left_applied_gain_o >= 7'h07 && right_applied_gain_o >= 7'h07)
        else $error("applied gain below floor");
    a_tie_at_floor: assert property ((!left_common_mode_tie_o || left_applied_gain_o == 7'h07)
        && (!right_common_mode_tie_o || right_applied_gain_o == 7'h07))
        else $error("tie active above floor gain");
    a_tie_after_settle: assert property ($rose(left_common_mode_tie_o) |-> $stable(left_applied_gain_o))
        else $error("tie rose while gain moving");
    a_single_step: assert property ($changed(left_applied_gain_o) |-> quiet_cnt >= STEP_CYCLES - 1
        && (left_applied_gain_o == $past(left_applied_gain_o) + 7'h01
        || left_applied_gain_o + 7'h01 == $past(left_applied_gain_o)))
        else $error("gain step too big or too early");
    a_reset_defaults: assert property ($fell(reset_i) |-> dc_block_corner_sel_o == 2'b11
        && audio_word_format_sel_o == 2'b11 && mclk_ratio_o == 10'd256 && sample_rate_code_o == 4'h0)
        else $error("defaults wrong after reset");
    a_oe_idle: assert property (ser_sel_n_i [*8] |=> ser_dout_oe_n_o)
        else $error("read driver on while deselected");
    c_unmute: cover property ($fell(left_common_mode_tie_o));
    c_mute: cover property ($rose(left_common_mode_tie_o));
    c_read: cover property ($fell(ser_dout_oe_n_o));
endmodule
bind acreg_control_bank acreg_control_bank_assertions #(.STEP_CYCLES(STEP_CYCLES)) i_acreg_control_bank_assertions (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .ser_sel_n_i(ser_sel_n_i), .ser_dout_oe_n_o(ser_dout_oe_n_o),
    .dc_block_corner_sel_o(dc_block_corner_sel_o), .filter_bypass_o(filter_bypass_o),
    .mic_preamp_gain_db_o(mic_preamp_gain_db_o), .mclk_ratio_o(mclk_ratio_o),
    .sample_rate_code_o(sample_rate_code_o), .rate_code_invalid_o(rate_code_invalid_o),
    .audio_word_format_sel_o(audio_word_format_sel_o), .left_applied_gain_o(left_applied_gain_o),
    .right_applied_gain_o(right_applied_gain_o), .left_common_mode_tie_o(left_common_mode_tie_o),
    .right_common_mode_tie_o(right_common_mode_tie_o));
`default_nettype wire

// ### sim/acreg_control_bank_tb.sv
// acreg_control_bank_tb.sv: self-checking bench for the codec control bank
// assumes: the host model drives the serial pins; step period shortened to 4 cycles
`timescale 1ns/100ps
`default_nettype none
module acreg_control_bank_tb;
    logic core_clk_i, reset_i, ser_clk, ser_sel_n, ser_din, ser_dout, ser_oe_n, bypass, invalid, ltie, rtie;
    logic [1:0] corner, lsrc, rsrc, fmt;
    logic [2:0] mic_preamp_gain_sel;
    logic [9:0] ratio;
    logic [3:0] rate;
    logic [6:0] lgain, rgain;
    logic [15:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    localparam int STEP = 4;
    // 250 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    acreg_host_model i_acreg_host_model (.ser_clk_o(ser_clk), .ser_sel_n_o(ser_sel_n), .ser_din_o(ser_din),
        .ser_dout_i(ser_dout));
    acreg_control_bank #(.STEP_CYCLES(STEP)) i_acreg_control_bank (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .ser_clk_i(ser_clk), .ser_sel_n_i(ser_sel_n), .ser_din_i(ser_din), .ser_dout_o(ser_dout),
        .ser_dout_oe_n_o(ser_oe_n), .dc_block_corner_sel_o(corner), .filter_bypass_o(bypass),
        .left_record_source_sel_o(lsrc), .right_record_source_sel_o(rsrc), .mic_preamp_gain_db_o(mic_preamp_gain_sel),
        .mclk_ratio_o(ratio), .sample_rate_code_o(rate), .rate_code_invalid_o(invalid),
        .audio_word_format_sel_o(fmt), .left_applied_gain_o(lgain), .right_applied_gain_o(rgain),
        .left_common_mode_tie_o(ltie), .right_common_mode_tie_o(rtie));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        i_acreg_host_model.xfer({1'b0, a, 9'h000, d}, 32, rd);
        repeat (4) @(negedge core_clk_i);
    endtask
    task automatic rdback(input logic [5:0] a, input logic [15:0] exp);
        i_acreg_host_model.xfer({1'b1, a, 9'h000, 16'h0000}, 32, rd);
        chk(rd, exp);
        chk(ser_oe_n, 1'b1);
    endtask
    task automatic t_defaults;
        chk({corner, lsrc, rsrc, mic_preamp_gain_sel, fmt, bypass}, {2'b11, 4'h0, 3'h0, 2'b11, 1'b0});
        chk({ratio, rate, ltie, rtie, lgain, rgain}, {10'd256, 4'h0, 2'b11, 7'h07, 7'h07});
        rdback(6'h00, 16'hc003);
        rdback(6'h01, 16'hd7d7);
        $display("test defaults done");
    endtask
    // every code of every field; rate walks all nine legal codes
    task automatic t_path;
        logic [1:0] k;
        logic [15:0] w;
        logic [2:0] mexp;
        logic [9:0] rexp;
        for (int r = 0; r <= 8; r++) begin
            k = r[1:0];
            w = {k, k, ~k, k, k, r[3:0], k}; // bench runs no audio clocks: any pair fits
            wr(6'h00, w);
            mexp = (k == 2'b10) ? 3'd6 : (k == 2'b11) ? 3'd4 : 3'd0;
            rexp = (k == 2'b01) ? 10'd384 : (k == 2'b10) ? 10'd512 : 10'd256;
            chk({corner, bypass, fmt}, {k, k == 2'b00, k});
            chk({lsrc, rsrc, mic_preamp_gain_sel, ratio}, {k, ~k, mexp, rexp});
            chk({rate, invalid}, {r[3:0], 1'b0});
            rdback(6'h00, w);
        end
        $display("test path config done");
    endtask
    // left opens to full gain, right stays muted by a code below the floor
    task automatic t_gain;
        wr(6'h01, 16'h7f03);
        repeat (140 * STEP) @(negedge core_clk_i);
        chk({lgain, ltie, rgain, rtie}, {7'h7f, 1'b0, 7'h07, 1'b1});
        wr(6'h01, 16'hff83);
        repeat (10 * STEP) @(negedge core_clk_i);
        chk(lgain > 7'h07 && !ltie, 1'b1);
        repeat (140 * STEP) @(negedge core_clk_i);
        chk({lgain, ltie}, {7'h07, 1'b1});
        rdback(6'h01, 16'hff83);
        $display("test gain stepping done");
    endtask
    // unmapped address and an aborted frame leave the bank unchanged
    task automatic t_refuse;
        wr(6'h05, 16'h1234);
        rdback(6'h05, 16'h0000);
        i_acreg_host_model.xfer(32'h0000_ffff, 20, rd);
        rdback(6'h00, 16'h0c20);
        $display("test refusals done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence: reset for 12 cycles, then the scenarios
    initial begin
        reset_i = 1'b1;
        repeat (12) @(negedge core_clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        t_defaults;
        t_path;
        t_gain;
        t_refuse;
        conclude;
    end
    // watchdog well past the expected run of about 15600 cycles
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        conclude;
    end
endmodule
`default_nettype wire
